/* include/oscr_defs.svh */
// constants for the output stage control register bank
// Function
// - low source select bits pick stages 1-8, reset 80
// - high source select bits pick stages 9-16, reset 00
// - low serial state bits, stages 1-8, reset ff
// - high serial state bits, stages 9-16, reset ff
// - extra serial state bits stages 17-18 reset one
// - extra register bits 7-2 ignore writes, read high
// - all five registers write and read back
// - select zero: serial bit drives stage, zero on
// - select one: parallel pin or fast bus
// - stages 17-18 driven only by serial bits
`ifndef OSCR_DEFS_SVH
`define OSCR_DEFS_SVH

// instruction codes, five bit field of the command byte
`define OSCR_INS_RD_SRC_LO 5'h02
`define OSCR_INS_RD_SRC_HI 5'h03
`define OSCR_INS_RD_SER_LO 5'h04
`define OSCR_INS_RD_SER_HI 5'h05
`define OSCR_INS_RD_SER_EX 5'h06
`define OSCR_INS_WR_SRC_LO 5'h12
`define OSCR_INS_WR_SRC_HI 5'h13
`define OSCR_INS_WR_SER_LO 5'h14
`define OSCR_INS_WR_SER_HI 5'h15
`define OSCR_INS_WR_SER_EX 5'h16

// reset values
`define OSCR_RST_SRC_LO 8'h80
`define OSCR_RST_SRC_HI 8'h00
`define OSCR_RST_SER_LO 8'hff
`define OSCR_RST_SER_HI 8'hff
`define OSCR_RST_SER_EX 2'h3

// extra serial state register layout
`define OSCR_EX_LSB 0
`define OSCR_EX_MSB 1
`define OSCR_EX_FILL 6'h3f

// index of the stage whose parallel pin is inverting (stage 8)
`define OSCR_INV_STAGE 7

`endif

/* include/oscr_pkg.sv */
// types shared by the output stage control register bank
package oscr_pkg;

   // one decoded transfer from the serial frame logic
   typedef struct packed {
      logic done;          // one-cycle pulse at end of transfer
      logic ok;            // transfer judged valid
      logic [4:0] instr;   // instruction field
      logic [7:0] wdata;   // data byte of a write
   } oscr_cmd_s;

   // read answer back to the serial frame logic
   typedef struct packed {
      logic valid;         // one-cycle pulse
      logic [7:0] data;    // register contents
   } oscr_rsp_s;

endpackage

/* core/oscr_stage_mux.sv */
// source selection for one parallel-capable power stage
`timescale 1ns/10ps
module oscr_stage_mux #(
   parameter bit INVERT_PAR = 1'b0,  // parallel pin is active low, set: active high
   parameter bit BUS_OK = 1'b1       // stage reachable by fast bus
) (
   // register bits
   input wire logic src_sel,
   input wire logic ser_state,
   // external sources
   input wire logic par_in,
   input wire logic bus_state,
   input wire logic bus_select,
   // result, one means stage on
   output logic stage_on
);

   // selection per the control truth table, before enabling
   always_comb begin
      if (!src_sel) begin
         stage_on = ~ser_state;
      end else if (bus_select) begin
         stage_on = INVERT_PAR ? par_in : ~par_in;
      end else begin
         // stage without fast bus access stays off
         stage_on = BUS_OK ? ~bus_state : 1'b0;
      end
   end

endmodule

/* core/oscr_regs.sv */
// source select and serial state registers with stage drive
`timescale 1ns/10ps
module oscr_regs
   import oscr_pkg::*;
#(
   parameter int STAGES_MUXED = 16,  // stages with a select bit
   parameter int REG_W = 8           // register width
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // decoded transfers and read answers
   input wire oscr_cmd_s cmd,
   output oscr_rsp_s rsp_q,
   // stage sources
   input wire logic [STAGES_MUXED-1:0] stage_parallel_input,
   input wire logic [STAGES_MUXED-1:0] fast_bus_state,
   input wire logic bus_select,
   input wire logic output_enable_flag,
   // stage drive, one means stage on
   output logic [STAGES_MUXED+1:0] power_stage_output
);

`include "oscr_defs.svh"

   // the bit layout is fixed by the instruction set, refused at elaboration
   if (STAGES_MUXED != 16 || REG_W != 8) begin : g_bad_params
      $error("oscr_regs supports 16 muxed stages, 8-bit registers");
   end

   // register state
   logic [REG_W-1:0] src_lo_q, src_lo_d;   // source_select_low
   logic [REG_W-1:0] src_hi_q, src_hi_d;   // source_select_high
   logic [REG_W-1:0] ser_lo_q, ser_lo_d;   // serial_state_low
   logic [REG_W-1:0] ser_hi_q, ser_hi_d;   // serial_state_high
   logic [1:0] ser_ex_q, ser_ex_d;         // serial_state_extra
   oscr_rsp_s rsp_d;                       // next read answer
   logic [STAGES_MUXED+1:0] out_q, out_d;  // stage drive

   // accepted transfer
   logic take;

   // a write counts only when the frame is finished and valid
   assign take = cmd.done && cmd.ok;

   // value read back for an instruction; upper extra bits read high
   function automatic logic [8:0] read_of(input logic [4:0] ins,
         input logic [7:0] a, input logic [7:0] b,
         input logic [7:0] c, input logic [7:0] d,
         input logic [1:0] e);
      read_of = 9'h000;
      unique case (ins)
         `OSCR_INS_RD_SRC_LO: read_of = {1'b1, a};
         `OSCR_INS_RD_SRC_HI: read_of = {1'b1, b};
         `OSCR_INS_RD_SER_LO: read_of = {1'b1, c};
         `OSCR_INS_RD_SER_HI: read_of = {1'b1, d};
         `OSCR_INS_RD_SER_EX: read_of = {1'b1, `OSCR_EX_FILL, e};
         default: read_of = 9'h000;   // other codes belong elsewhere
      endcase
   endfunction

   // next register values from an accepted write
   always_comb begin
      src_lo_d = src_lo_q;
      src_hi_d = src_hi_q;
      ser_lo_d = ser_lo_q;
      ser_hi_d = ser_hi_q;
      ser_ex_d = ser_ex_q;
      if (take) begin
         unique case (cmd.instr)
            `OSCR_INS_WR_SRC_LO: src_lo_d = cmd.wdata;
            `OSCR_INS_WR_SRC_HI: src_hi_d = cmd.wdata;
            `OSCR_INS_WR_SER_LO: ser_lo_d = cmd.wdata;
            `OSCR_INS_WR_SER_HI: ser_hi_d = cmd.wdata;
            // only the two stage bits are stored
            `OSCR_INS_WR_SER_EX:
               ser_ex_d = cmd.wdata[`OSCR_EX_MSB:`OSCR_EX_LSB];
            default: ;   // reads and foreign codes leave the bank alone
         endcase
      end
   end

   // read answer; the value before any write of the same cycle
   always_comb begin
      logic [8:0] rv;
      rv = read_of(cmd.instr, src_lo_q, src_hi_q, ser_lo_q, ser_hi_q,
         ser_ex_q);
      rsp_d.valid = take && rv[8];
      rsp_d.data = take ? rv[7:0] : rsp_q.data;  // hold last answer
   end

   // register bank and answer flops
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         src_lo_q <= `OSCR_RST_SRC_LO;
         src_hi_q <= `OSCR_RST_SRC_HI;
         ser_lo_q <= `OSCR_RST_SER_LO;
         ser_hi_q <= `OSCR_RST_SER_HI;
         ser_ex_q <= `OSCR_RST_SER_EX;
         rsp_q <= '0;
      end else begin
         src_lo_q <= src_lo_d;
         src_hi_q <= src_hi_d;
         ser_lo_q <= ser_lo_d;
         ser_hi_q <= ser_hi_d;
         ser_ex_q <= ser_ex_d;
         rsp_q <= rsp_d;
      end
   end

   // per-stage selection
   logic [STAGES_MUXED-1:0] src_all, ser_all, sel_on;
   assign src_all = {src_hi_q, src_lo_q};
   assign ser_all = {ser_hi_q, ser_lo_q};

   genvar gi;
   generate
      for (gi = 0; gi < STAGES_MUXED; gi++) begin : g_stage
         // stage 8 has an inverting pin and no fast bus path
         oscr_stage_mux #(
            .INVERT_PAR(gi == `OSCR_INV_STAGE),
            .BUS_OK(gi != `OSCR_INV_STAGE)
         ) u_mux (
            .src_sel(src_all[gi]),
            .ser_state(ser_all[gi]),
            .par_in(stage_parallel_input[gi]),
            .bus_state(fast_bus_state[gi]),
            .bus_select(bus_select),
            .stage_on(sel_on[gi])
         );
      end
   endgenerate

   // stage drive, gated by the enable flag; reset forces all off
   always_comb begin
      if (output_enable_flag) begin
         // stages 17 and 18 follow their serial bits only
         out_d = {~ser_ex_q, sel_on};
      end else begin
         out_d = '0;
      end
   end

   // registered so the pins never glitch on select changes
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign power_stage_output = out_q;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // an accepted write of a given code
   sequence s_write(logic [4:0] code);
      take && cmd.instr == code;
   endsequence

   // an accepted read of a given code
   sequence s_read(logic [4:0] code);
      take && cmd.instr == code;
   endsequence

   a_src_lo_reset: assert property (
      reset_n && $past(!reset_n) |-> src_lo_q == 8'h80)
      else $error("low source select not 80 after reset");

   a_reset_values: assert property (
      reset_n && $past(!reset_n) |-> src_hi_q == 8'h00 &&
         ser_lo_q == 8'hff && ser_hi_q == 8'hff && ser_ex_q == 2'h3)
      else $error("register reset values wrong");

   a_src_hi_write: assert property (
      s_write(`OSCR_INS_WR_SRC_HI) |=> src_hi_q == $past(cmd.wdata))
      else $error("high source select write lost");

   a_ser_lo_write: assert property (
      s_write(`OSCR_INS_WR_SER_LO) |=> ser_lo_q == $past(cmd.wdata))
      else $error("low serial state write lost");

   a_extra_readback: assert property (
      s_write(`OSCR_INS_WR_SER_EX) ##1 s_read(`OSCR_INS_RD_SER_EX)
      |=> rsp_q.valid && rsp_q.data == {6'h3f, $past(cmd.wdata[1:0], 2)})
      else $error("extra serial state readback wrong");

   a_readback_low: assert property (
      s_read(`OSCR_INS_RD_SRC_LO) |=> rsp_q.valid &&
         rsp_q.data == $past(src_lo_q))
      else $error("low source select readback wrong");

   a_rejected_hold: assert property (
      cmd.done && !cmd.ok |=> $stable(src_lo_q) && $stable(src_hi_q) &&
         $stable(ser_lo_q) && $stable(ser_hi_q) && $stable(ser_ex_q)
         && !rsp_q.valid)
      else $error("rejected transfer changed the bank");

   a_serial_drive: assert property (
      output_enable_flag && !src_lo_q[0] |=>
         power_stage_output[0] == !$past(ser_lo_q[0]))
      else $error("stage 1 does not follow its serial bit");

   a_parallel_drive: assert property (
      output_enable_flag && src_lo_q[1] && bus_select |=>
         power_stage_output[1] == !$past(stage_parallel_input[1]))
      else $error("stage 2 does not follow its pin");

   a_extra_stages: assert property (
      1'b1 |=> power_stage_output[17:16] ==
         ($past(output_enable_flag) ? ~$past(ser_ex_q) : 2'b00))
      else $error("stages 17-18 not driven by serial bits");

endmodule

/* tb/oscr_host_model.sv */
// stand-in for the serial master that hands decoded transfers to the bank
`timescale 1ns/10ps
module oscr_host_model
   import oscr_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // transfers out, answers back
   output oscr_cmd_s cmd,
   input wire oscr_rsp_s rsp_q
);
   // idle, no transfer pending
   initial cmd = '0;

   // one transfer, launched on a falling edge, answer taken one edge on,
   // then one idle cycle so a write has reached the stage drive
   task automatic xfer(input logic ok, input logic [4:0] ins,
         input logic [7:0] wd, output oscr_rsp_s seen);
      @(negedge clk_sys);
      cmd = '{1'b1, ok, ins, wd};
      @(negedge clk_sys);
      // the answer stands only in the cycle after the taking edge
      seen = rsp_q;
      // released fields flip so stale values cannot pass for live ones
      cmd = '{1'b0, 1'b0, ~ins, ~wd};
      @(negedge clk_sys);
   endtask

   // a write and a read in consecutive cycles, read answer returned
   task automatic xfer_pair(input logic [4:0] wins, input logic [7:0] wd,
         input logic [4:0] rins, output oscr_rsp_s seen);
      @(negedge clk_sys);
      cmd = '{1'b1, 1'b1, wins, wd};
      @(negedge clk_sys);
      // back to back transfers are legal, done stays high
      cmd = '{1'b1, 1'b1, rins, 8'h00};
      @(negedge clk_sys);
      seen = rsp_q;
      cmd = '{1'b0, 1'b0, ~rins, 8'hff};
      @(negedge clk_sys);
   endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the output stage control register bank
`timescale 1ns/10ps
`include "oscr_defs.svh"
module tb;
   import oscr_pkg::*;
   // clock, reset, bank ports
   logic clk_sys;
   logic reset_n;
   oscr_cmd_s cmd;
   oscr_rsp_s rsp_q;
   oscr_rsp_s seen;
   logic [15:0] par_in;
   logic [15:0] fast_st;
   logic bsel;
   logic oe;
   logic [17:0] stage_out;
   // bookkeeping
   int bad_count = 0;
   int num_checks = 0;
   int cycle_count = 0;

   oscr_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd),
      .rsp_q(rsp_q), .stage_parallel_input(par_in),
      .fast_bus_state(fast_st), .bus_select(bsel),
      .output_enable_flag(oe), .power_stage_output(stage_out));
   oscr_host_model host_u (.clk_sys(clk_sys), .cmd(cmd), .rsp_q(rsp_q));

   // 50 ns period
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   // hang guard, far above the hundred or so cycles the run needs
   always @(posedge clk_sys) begin
      cycle_count++;
      if (cycle_count == 3000) begin
         bad_count++;
         stop_test();
      end
   end

   // verdict and end of run
   task automatic stop_test();
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // compare seen against expected
   task automatic check(input logic [17:0] s, input logic [17:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // valid write and valid read with answer compare
   task automatic wr(input logic [4:0] ins, input logic [7:0] d);
      host_u.xfer(1'b1, ins, d, seen);
   endtask
   task automatic rd(input logic [4:0] ins, input logic [7:0] e);
      host_u.xfer(1'b1, ins, 8'h00, seen);
      check(18'({seen.valid, seen.data}), 18'({1'b1, e}));
   endtask

   // stage drive expected from register images and current pins
   function automatic logic [17:0] exp_out(input logic [15:0] src,
         input logic [15:0] ser, input logic [1:0] ex);
      logic [17:0] o;
      for (int i = 0; i < 16; i++)
         o[i] = !src[i] ? !ser[i] : bsel ? ((i == 7) ^ !par_in[i])
            : (i != 7 && !fast_st[i]);
      o[17:16] = ~ex;
      return oe ? o : 18'h0;
   endfunction

   // reset contents and the drive they give
   task automatic t_reset();
      rd(`OSCR_INS_RD_SRC_LO, 8'h80);
      rd(`OSCR_INS_RD_SRC_HI, 8'h00);
      rd(`OSCR_INS_RD_SER_LO, 8'hff);
      rd(`OSCR_INS_RD_SER_HI, 8'hff);
      rd(`OSCR_INS_RD_SER_EX, 8'hff);
      check(stage_out, exp_out(16'h0080, 16'hffff, 2'h3));
   endtask

   // all five written first, then read back to catch crosstalk
   task automatic t_rw();
      logic [7:0] v;
      for (int i = 0; i < 5; i++) begin
         v = 8'h5a + 8'(i * 17);
         wr(`OSCR_INS_WR_SRC_LO + 5'(i), v);
      end
      for (int i = 0; i < 5; i++) begin
         v = 8'h5a + 8'(i * 17);
         if (i == 4)
            v = {6'h3f, v[1:0]};
         rd(`OSCR_INS_RD_SRC_LO + 5'(i), v);
      end
   endtask

   // invalid transfers must change nothing and answer nothing
   task automatic t_reject();
      host_u.xfer(1'b0, `OSCR_INS_WR_SRC_LO, 8'h11, seen);
      host_u.xfer(1'b0, `OSCR_INS_RD_SRC_LO, 8'h00, seen);
      check(18'(seen.valid), 18'h0);
      rd(`OSCR_INS_RD_SRC_LO, 8'h5a);
   endtask

   // extra register written and read back in consecutive cycles
   task automatic t_pair();
      host_u.xfer_pair(`OSCR_INS_WR_SER_EX, 8'h01, `OSCR_INS_RD_SER_EX,
         seen);
      check(18'({seen.valid, seen.data}), 18'h1fd);
   endtask

   // serial control, then enable removed
   task automatic t_serial();
      wr(`OSCR_INS_WR_SRC_LO, 8'h00);
      wr(`OSCR_INS_WR_SRC_HI, 8'h00);
      wr(`OSCR_INS_WR_SER_LO, 8'ha5);
      wr(`OSCR_INS_WR_SER_HI, 8'h3c);
      wr(`OSCR_INS_WR_SER_EX, 8'h02);
      check(stage_out, exp_out(16'h0000, 16'h3ca5, 2'h2));
      oe = 1'b0;
      @(negedge clk_sys);
      check(stage_out, 18'h0);
      oe = 1'b1;
   endtask

   // pin control, then fast bus control; stage 8 is the odd one
   task automatic t_parallel();
      wr(`OSCR_INS_WR_SRC_LO, 8'hff);
      wr(`OSCR_INS_WR_SRC_HI, 8'hff);
      par_in = 16'h35c3;
      @(negedge clk_sys);
      check(stage_out, exp_out(16'hffff, 16'h3ca5, 2'h2));
      bsel = 1'b0;
      fast_st = 16'h0f0f;
      @(negedge clk_sys);
      check(stage_out, exp_out(16'hffff, 16'h3ca5, 2'h2));
   endtask

   // main sequence
   initial begin
      reset_n = 1'b0;
      oe = 1'b1;
      bsel = 1'b1;
      par_in = 16'h0080;
      fast_st = 16'hffff;
      repeat (16) @(negedge clk_sys);
      check(stage_out, 18'h0);
      reset_n = 1'b1;
      t_reset();
      t_rw();
      t_reject();
      t_pair();
      t_serial();
      t_parallel();
      stop_test();
   end
endmodule
